// File: src/filter_chain_pkg.sv
// constants shared by the measurement filter chain and its helpers
// assumes one clock domain and a plain strobe-based register port
package filter_chain_pkg;
   localparam int SAMPLE_W = 24;
   localparam int RANK_W   = 4;
   localparam int COUNT_W  = 7;
   localparam int WIN_MAX  = 31;
   localparam int MAVG_MAX = 100;
   localparam int FIFO_DEPTH = 4;

   // register offsets (byte addresses)
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_SETUP  = 8'h04;
   localparam logic [7:0] ADDR_MEAS   = 8'h08;
   localparam logic [7:0] ADDR_KEY    = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   // field positions
   localparam int CFG_MEDIAN_BIT   = 0;
   localparam int CFG_MAVG_BIT     = 1;
   localparam int SETUP_RANK_LSB   = 0;
   localparam int SETUP_COUNT_LSB  = 8;
   localparam int MEAS_MODE_LSB    = 0;
   localparam int MEAS_APER_LSB    = 4;
   localparam int KEY_PRESS_BIT    = 0;
   localparam int KEY_CONFIRM_BIT  = 1;
   localparam int STAT_IND_BIT     = 0;
   localparam int STAT_MED_BIT     = 1;
   localparam int STAT_MAVG_BIT    = 2;
   localparam int STAT_SHIFT_LSB   = 4;
   localparam int STAT_LEVEL_LSB   = 8;

   // limits and reset values
   localparam logic [COUNT_W-1:0] COUNT_MIN = 7'h01;
   localparam logic [COUNT_W-1:0] COUNT_MAX = 7'h64;
   localparam logic [RANK_W-1:0]  RST_RANK  = 4'h0;
   localparam logic [COUNT_W-1:0] RST_COUNT = 7'h0a;
   localparam logic [2:0]         RST_APER  = 3'h3;
   localparam logic [2:0]         APER_LAST = 3'h5;

   // block length as log2, one entry per aperture step 0.001 .. 100 plc
   localparam logic [2:0] BLK_SHIFT_0 = 3'h0;
   localparam logic [2:0] BLK_SHIFT_1 = 3'h0;
   localparam logic [2:0] BLK_SHIFT_2 = 3'h1;
   localparam logic [2:0] BLK_SHIFT_3 = 3'h2;
   localparam logic [2:0] BLK_SHIFT_4 = 3'h3;
   localparam logic [2:0] BLK_SHIFT_5 = 3'h4;

   typedef enum logic [1:0] {MODE_CURRENT, MODE_VOLTAGE, MODE_CHARGE, MODE_RESISTANCE} meas_mode_t;
   typedef enum logic {DIV_IDLE, DIV_RUN} div_state_t;

   function automatic logic [2:0] block_shift(input logic [2:0] aper);
      case (aper)
         3'h0: block_shift = BLK_SHIFT_0;
         3'h1: block_shift = BLK_SHIFT_1;
         3'h2: block_shift = BLK_SHIFT_2;
         3'h3: block_shift = BLK_SHIFT_3;
         3'h4: block_shift = BLK_SHIFT_4;
         default: block_shift = BLK_SHIFT_5;
      endcase
   endfunction
endpackage

// File: src/sample_fifo.sv
// output fifo between the filter chain and the display side
// assumes the reader may stall; full and empty are exact
`timescale 1ns/1ps
module sample_fifo #(
   parameter int W     = 24,
   parameter int DEPTH = 4,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   output logic [AW:0]       level
);
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic          push;
   logic          pop;

   function automatic logic [AW-1:0] wrap(input logic [AW-1:0] p);
      wrap = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction

   assign in_ready  = (level != (AW+1)'(DEPTH));
   assign out_valid = (level != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rptr];

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
         wptr <= '0;
      end else if (push) begin
         mem[wptr] <= in_data;
         wptr      <= wrap(wptr);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rptr  <= '0;
         level <= '0;
      end else begin
         if (pop) rptr <= wrap(rptr);
         level <= level + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// File: src/median_window.sv
// sliding median over the newest 2*rank+1 samples
// assumes flush is only raised while no sample is in flight
`timescale 1ns/1ps
module median_window #(
   parameter int W       = 24,
   parameter int WIN_MAX = 31,
   parameter int RANK_W  = 4
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic              flush,
   input  wire logic [RANK_W-1:0] rank,
   input  wire logic              in_valid,
   input  wire logic [W-1:0]      in_data,
   output logic                   out_valid,
   output logic [W-1:0]           out_data,
   output logic                   busy
);
   logic signed [W-1:0] win [WIN_MAX];
   logic [5:0]          fill;
   logic [5:0]          len;
   logic                pending;
   logic signed [W-1:0] median;
   logic [5:0]          less;
   logic [5:0]          same;

   assign len  = {1'b0, rank, 1'b1};
   assign busy = pending;

   // newest at index 0; the oldest falls off the end of the active length
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < WIN_MAX; i++) win[i] <= '0;
         fill    <= '0;
         pending <= 1'b0;
      end else if (flush) begin
         fill    <= '0;
         pending <= 1'b0;
      end else begin
         if (in_valid) begin
            win[0] <= in_data;
            for (int i = 1; i < WIN_MAX; i++) win[i] <= win[i-1];
            if (fill < len) fill <= fill + 6'd1;
         end
         pending <= in_valid & ((fill + 6'd1) >= len);
      end
   end

   // rank counting: the entry with at most rank smaller values and more than rank
   // smaller-or-equal values is the middle one, so duplicates need no sort network
   always_comb begin
      median = '0;
      less   = '0;
      same   = '0;
      for (int i = 0; i < WIN_MAX; i++) begin
         if (i < int'(len)) begin
            less = '0;
            same = '0;
            for (int j = 0; j < WIN_MAX; j++) begin
               if (j < int'(len)) begin
                  if (win[j] < win[i]) less = less + 6'd1;
                  else if (win[j] == win[i]) same = same + 6'd1;
               end
            end
            if ((less <= 6'(rank)) && ((less + same) > 6'(rank))) median = win[i];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         out_valid <= pending & ~flush;
         if (pending) out_data <= median;
      end
   end
endmodule

// File: src/filter_chain.sv
// measurement noise filter chain: block averager, median, moving average, output fifo
// assumes samples and register strobes come from logic on sys_clk
//
// Summary of operation
// - The block averager sums N consecutive samples, divides by N and starts afresh on the next N.
// - The block averager always sits in the sample path and nothing bypasses it.
// - The block length is chosen from the aperture setting, not programmed by software.
// - The median stage acts only in current mode and is bypassed in every other mode.
// - The median stage keeps the newest N samples and emits their middle value, sliding by one.
// - The median window is twice the rank plus one, with rank limited to 0 through 15.
// - The moving average emits the sum of the newest N samples over N, sliding by one per result.
// - The moving-average length is programmable from 1 to 100 samples.
// - With both optional stages on, the moving average is fed by median results.
// - Confirming setup enables both stages and lights the indicator; a key press while lit undoes both.
// - The setup path changes only rank and count, never the stage enables.
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module filter_chain
   import filter_chain_pkg::*;
#(
   parameter int W     = filter_chain_pkg::SAMPLE_W,
   parameter int DEPTH = filter_chain_pkg::FIFO_DEPTH
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic [7:0]   reg_addr,
   input  wire logic [31:0]  reg_wdata,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   output logic [31:0]       reg_rdata,
   input  wire logic         sample_valid,
   output logic              sample_ready,
   input  wire logic [W-1:0] sample_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   output logic              filter_active_indicator
);
   import filter_chain_pkg::*;

   localparam int SUMW = W + COUNT_W;
   localparam int LW   = $clog2(DEPTH) + 1;

   // software state
   logic               median_en;
   logic               mavg_en;
   logic [RANK_W-1:0]  rank;
   logic [COUNT_W-1:0] count;
   meas_mode_t         mode;
   logic [2:0]         aperture;

   // block averager
   logic [2:0]             blk_shift;
   logic [4:0]             blk_cnt;
   logic signed [SUMW-1:0] blk_acc;
   logic signed [SUMW-1:0] blk_sum;
   logic                   blk_last;
   logic                   blk_valid;
   logic [W-1:0]           blk_data;
   logic                   blk_reload;

   // median stage
   logic              med_on;
   logic [RANK_W-1:0] med_rank;
   logic              med_flush;
   logic              med_valid;
   logic [W-1:0]      med_data;
   logic              med_busy;

   // moving average stage
   logic                   mavg_on;
   logic [COUNT_W-1:0]     mavg_len;
   logic                   mavg_reload;
   logic [W-1:0]           mbuf [MAVG_MAX];
   logic [COUNT_W-1:0]     mptr;
   logic [COUNT_W-1:0]     mfill;
   logic signed [SUMW-1:0] msum;
   logic signed [SUMW-1:0] next_msum;
   logic                   mavg_in;
   div_state_t             div_state;
   logic [COUNT_W:0]       div_rem;
   logic [SUMW-1:0]        div_quo;
   logic [COUNT_W-1:0]     div_den;
   logic                   div_neg;
   logic [5:0]             div_step;
   logic [COUNT_W:0]       div_shifted;
   logic                   mavg_valid;
   logic [W-1:0]           mavg_data;

   // chain plumbing
   logic         s2_valid;
   logic [W-1:0] s2_data;
   logic         fin_valid;
   logic [W-1:0] fin_data;
   logic         fifo_in_ready;
   logic [LW-1:0] fifo_level;
   logic         pipe_busy;
   logic         accept;
   logic         key_press;
   logic         key_confirm;

   function automatic logic signed [SUMW-1:0] widen(input logic [W-1:0] v);
      widen = {{(SUMW-W){v[W-1]}}, v};
   endfunction

   // ---------------- register port ----------------
   assign key_press   = reg_wr & (reg_addr == ADDR_KEY) & reg_wdata[KEY_PRESS_BIT];
   assign key_confirm = reg_wr & (reg_addr == ADDR_KEY) & reg_wdata[KEY_CONFIRM_BIT];

   // enables are reached by the config register and the filter key only
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         median_en               <= 1'b0;
         mavg_en                 <= 1'b0;
         filter_active_indicator <= 1'b0;
      end else if (key_press && filter_active_indicator) begin
         median_en               <= 1'b0;
         mavg_en                 <= 1'b0;
         filter_active_indicator <= 1'b0;
      end else if (key_confirm) begin
         median_en               <= 1'b1;
         mavg_en                 <= 1'b1;
         filter_active_indicator <= 1'b1;
      end else if (reg_wr && reg_addr == ADDR_CONFIG) begin
         median_en               <= reg_wdata[CFG_MEDIAN_BIT];
         mavg_en                 <= reg_wdata[CFG_MAVG_BIT];
         filter_active_indicator <= reg_wdata[CFG_MEDIAN_BIT] | reg_wdata[CFG_MAVG_BIT];
      end
   end

   // the setup register holds parameters only; out-of-range counts are dropped
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rank  <= RST_RANK;
         count <= RST_COUNT;
      end else if (reg_wr && reg_addr == ADDR_SETUP) begin
         rank <= reg_wdata[SETUP_RANK_LSB +: RANK_W];
         if (reg_wdata[SETUP_COUNT_LSB +: COUNT_W] >= COUNT_MIN &&
             reg_wdata[SETUP_COUNT_LSB +: COUNT_W] <= COUNT_MAX) begin
            count <= reg_wdata[SETUP_COUNT_LSB +: COUNT_W];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mode     <= MODE_CURRENT;
         aperture <= RST_APER;
      end else if (reg_wr && reg_addr == ADDR_MEAS) begin
         mode <= meas_mode_t'(reg_wdata[MEAS_MODE_LSB +: 2]);
         if (reg_wdata[MEAS_APER_LSB +: 3] <= APER_LAST) aperture <= reg_wdata[MEAS_APER_LSB +: 3];
      end
   end

   // read data stands only in the cycle after the strobe; unmapped reads give zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else begin
         reg_rdata <= '0;
         if (reg_rd) begin
            unique case (reg_addr)
               ADDR_CONFIG: begin
                  reg_rdata[CFG_MEDIAN_BIT] <= median_en;
                  reg_rdata[CFG_MAVG_BIT]   <= mavg_en;
               end
               ADDR_SETUP: begin
                  reg_rdata[SETUP_RANK_LSB +: RANK_W]   <= rank;
                  reg_rdata[SETUP_COUNT_LSB +: COUNT_W] <= count;
               end
               ADDR_MEAS: begin
                  reg_rdata[MEAS_MODE_LSB +: 2] <= mode;
                  reg_rdata[MEAS_APER_LSB +: 3] <= aperture;
               end
               ADDR_STATUS: begin
                  reg_rdata[STAT_IND_BIT]            <= filter_active_indicator;
                  reg_rdata[STAT_MED_BIT]            <= med_on;
                  reg_rdata[STAT_MAVG_BIT]           <= mavg_on;
                  reg_rdata[STAT_SHIFT_LSB +: 3]     <= blk_shift;
                  reg_rdata[STAT_LEVEL_LSB +: LW]    <= fifo_level;
               end
               default: reg_rdata <= '0;
            endcase
         end
      end
   end

   // ---------------- flow control ----------------
   // one result in flight at a time: a sample is taken only when the fifo can hold
   // whatever it may produce, trading throughput for a simple, lossless pipeline
   assign med_on    = median_en & (mode == MODE_CURRENT);
   assign mavg_on   = mavg_en;
   assign pipe_busy = blk_valid | med_busy | med_valid | (div_state == DIV_RUN) | mavg_valid;

   assign blk_reload  = (block_shift(aperture) != blk_shift) & ~pipe_busy;
   assign med_flush   = (((rank != med_rank) | ~med_on) & ~pipe_busy) | ~rstn;
   assign mavg_reload = ((count != mavg_len) | ~mavg_on) & ~pipe_busy;

   assign sample_ready = fifo_in_ready & ~pipe_busy & ~blk_reload;
   assign accept       = sample_valid & sample_ready;

   // ---------------- block averager ----------------
   assign blk_sum  = blk_acc + widen(sample_data);
   assign blk_last = (blk_cnt == 5'((6'd1 << blk_shift) - 6'd1));

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         blk_shift <= BLK_SHIFT_0;
         blk_cnt   <= '0;
         blk_acc   <= '0;
      end else if (blk_reload) begin
         blk_shift <= block_shift(aperture);
         blk_cnt   <= '0;
         blk_acc   <= '0;
      end else if (accept) begin
         if (blk_last) begin
            blk_cnt <= '0;
            blk_acc <= '0;
         end else begin
            blk_cnt <= blk_cnt + 5'd1;
            blk_acc <= blk_sum;
         end
      end
   end

   // every sample goes through here whatever the settings
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         blk_valid <= 1'b0;
         blk_data  <= '0;
      end else begin
         blk_valid <= accept & blk_last & ~blk_reload;
         if (accept && blk_last) blk_data <= W'(blk_sum >>> blk_shift);
      end
   end

   // ---------------- median stage ----------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) med_rank <= RST_RANK;
      else if (~pipe_busy) med_rank <= rank;
   end

   median_window #(
      .W       (W),
      .WIN_MAX (WIN_MAX),
      .RANK_W  (RANK_W)
   ) u_median (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .flush     (med_flush),
      .rank      (med_rank),
      .in_valid  (blk_valid & med_on),
      .in_data   (blk_data),
      .out_valid (med_valid),
      .out_data  (med_data),
      .busy      (med_busy)
   );

   assign s2_valid = med_on ? med_valid : blk_valid;
   assign s2_data  = med_on ? med_data : blk_data;

   // ---------------- moving average stage ----------------
   assign mavg_in   = s2_valid & mavg_on;
   assign next_msum = (mfill == mavg_len) ? msum + widen(s2_data) - widen(mbuf[mptr])
                                          : msum + widen(s2_data);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < MAVG_MAX; i++) mbuf[i] <= '0;
      end else if (mavg_in) begin
         mbuf[mptr] <= s2_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mavg_len <= RST_COUNT;
         mptr     <= '0;
         mfill    <= '0;
         msum     <= '0;
      end else if (mavg_reload) begin
         mavg_len <= count;
         mptr     <= '0;
         mfill    <= '0;
         msum     <= '0;
      end else if (mavg_in) begin
         msum <= next_msum;
         mptr <= (mptr == mavg_len - COUNT_MIN) ? '0 : mptr + COUNT_MIN;
         if (mfill != mavg_len) mfill <= mfill + COUNT_MIN;
      end
   end

   // restoring divider on the magnitude; quotient truncates toward zero
   assign div_shifted = {div_rem[COUNT_W-1:0], div_quo[SUMW-1]};

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         div_state <= DIV_IDLE;
         div_rem   <= '0;
         div_quo   <= '0;
         div_den   <= COUNT_MIN;
         div_neg   <= 1'b0;
         div_step  <= '0;
      end else begin
         unique case (div_state)
            DIV_IDLE: begin
               if (mavg_in && (mfill == mavg_len || mfill + COUNT_MIN == mavg_len)) begin
                  div_state <= DIV_RUN;
                  div_rem   <= '0;
                  div_quo   <= next_msum[SUMW-1] ? SUMW'(-next_msum) : next_msum;
                  div_neg   <= next_msum[SUMW-1];
                  div_den   <= mavg_len;
                  div_step  <= '0;
               end
            end
            DIV_RUN: begin
               if (div_shifted >= {1'b0, div_den}) begin
                  div_rem <= div_shifted - {1'b0, div_den};
                  div_quo <= {div_quo[SUMW-2:0], 1'b1};
               end else begin
                  div_rem <= div_shifted;
                  div_quo <= {div_quo[SUMW-2:0], 1'b0};
               end
               div_step <= div_step + 6'd1;
               if (div_step == 6'(SUMW - 1)) div_state <= DIV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mavg_valid <= 1'b0;
         mavg_data  <= '0;
      end else begin
         mavg_valid <= 1'b0;
         if (div_state == DIV_RUN && div_step == 6'(SUMW - 1)) begin
            mavg_valid <= 1'b1;
            mavg_data  <= div_neg ? W'(-{div_quo[SUMW-2:0], div_shifted >= {1'b0, div_den}})
                                  : W'({div_quo[SUMW-2:0], div_shifted >= {1'b0, div_den}});
         end
      end
   end

   assign fin_valid = mavg_on ? mavg_valid : s2_valid;
   assign fin_data  = mavg_on ? mavg_data : s2_data;

   // ---------------- output buffer ----------------
   sample_fifo #(
      .W     (W),
      .DEPTH (DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_valid  (fin_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fin_data),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_data),
      .level     (fifo_level)
   );
endmodule

// File: dv/filter_chain_sva.sv
// checker for the filter chain register port, indicator and output fifo
// assumes it is bound to every filter_chain instance
`timescale 1ns/1ps
module filter_chain_sva
   import filter_chain_pkg::*;
#(parameter int W = 24) (
   input wire logic         sys_clk,
   input wire logic         rstn,
   input wire logic [7:0]   reg_addr,
   input wire logic [31:0]  reg_wdata,
   input wire logic         reg_wr,
   input wire logic         reg_rd,
   input wire logic [31:0]  reg_rdata,
   input wire logic         out_valid,
   input wire logic         out_ready,
   input wire logic [W-1:0] out_data,
   input wire logic         filter_active_indicator
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire key_wr = reg_wr && reg_addr == ADDR_KEY;
   wire stat_rd = reg_rd && reg_addr == ADDR_STATUS;
   sequence s_confirm; key_wr && reg_wdata[1:0] == 2'b10; endsequence
   sequence s_aper; reg_wr && reg_addr == ADDR_MEAS && reg_wdata[6:4] <= APER_LAST; endsequence
   property p_confirm; s_confirm |=> filter_active_indicator; endproperty
   property p_press; key_wr && reg_wdata[0] && filter_active_indicator |=> !filter_active_indicator; endproperty
   property p_cause; $changed(filter_active_indicator) |-> $past(reg_wr); endproperty
   property p_setup; reg_wr && reg_addr == ADDR_SETUP |=> $stable(filter_active_indicator); endproperty
   property p_stat_ind; stat_rd |=> reg_rdata[0] == $past(filter_active_indicator); endproperty
   property p_stat_en; s_confirm ##1 stat_rd |=> reg_rdata[2] && reg_rdata[0]; endproperty
   // the write sits four cycles back when the status word lands
   property p_aper; s_aper ##3 stat_rd |=> reg_rdata[6:4] ==
      ($past(reg_wdata[6:4], 4) < 2 ? 0 : $past(reg_wdata[6:4], 4) - 1); endproperty
   property p_fifo; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
   a_confirm: assert property (p_confirm) else $error("confirm left indicator dark");
   a_press: assert property (p_press) else $error("press left indicator lit");
   a_cause: assert property (p_cause) else $error("indicator moved without a write");
   a_setup: assert property (p_setup) else $error("setup write moved indicator");
   a_stat_ind: assert property (p_stat_ind) else $error("status bit 0 differs from indicator");
   a_stat_en: assert property (p_stat_en) else $error("confirm did not set enables");
   a_aper: assert property (p_aper) else $error("block length not from aperture");
   a_fifo: assert property (p_fifo) else $error("stalled fifo head moved");
endmodule
bind filter_chain filter_chain_sva #(.W(W)) filter_chain_sva_i (.*);

// File: dv/display_sink.sv
// display side: takes fifo words promptly, every other cycle, or not at all
// assumes hold and slow come from the bench on sys_clk
`timescale 1ns/1ps
module display_sink #(parameter int W = 24) (
   input wire logic         sys_clk,
   input wire logic         rstn,
   input wire logic         hold,
   input wire logic         slow,
   input wire logic         out_valid,
   input wire logic [W-1:0] out_data,
   output logic             out_ready
);
   logic [W-1:0] got [$];
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) out_ready <= 1'b0;
      else out_ready <= !hold && (!slow || !out_ready);
   end
   always @(posedge sys_clk) if (rstn && out_valid && out_ready) got.push_back(out_data);
endmodule

// File: dv/filter_chain_bench.sv
// bench: table of filter setups over one sample stream, then register and fifo cases
// assumes display_sink collects every word that leaves the fifo
`timescale 1ns/1ps
module filter_chain_bench;
   import filter_chain_pkg::*;
   typedef struct {logic [2:0] a; logic [1:0] m, en; logic [3:0] rk; logic [6:0] c; int n; logic [23:0] e [8];} row_t;
   localparam logic [23:0] S [8] = '{1, 2, 100, 5, 6, 9, 3, 7};
   // aperture, mode, enables, rank, count, results, expected results
   row_t rows [7] = '{'{0,0,0,1,2,8,'{1,2,100,5,6,9,3,7}}, '{2,0,0,1,2,4,'{1,52,7,5,0,0,0,0}},
      '{0,0,1,1,2,6,'{2,5,6,6,6,7,0,0}}, '{0,1,1,1,2,8,'{1,2,100,5,6,9,3,7}},
      '{0,0,2,1,2,7,'{1,51,52,5,7,6,5,0}}, '{0,0,3,1,2,5,'{3,5,6,6,6,0,0,0}},
      '{0,0,1,0,1,8,'{1,2,100,5,6,9,3,7}}};
   logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, sample_valid = 0, hold = 0, slow = 0, ok;
   logic [7:0] reg_addr = 0;
   logic [31:0] reg_wdata = 0, reg_rdata, x;
   logic [23:0] sample_data = 0, out_data;
   logic sample_ready, out_valid, out_ready, filter_active_indicator;
   int num_errors = 0, total_checks = 0, cycles = 0;
   always #25 sys_clk = ~sys_clk;
   filter_chain filter_chain_i (.*);
   display_sink display_sink_i (.sys_clk, .rstn, .hold, .slow, .out_valid, .out_data, .out_ready);
   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // strobes stay as set until the next call, so back-to-back accesses never reassign in one step
   task automatic bus(input logic w, r, input logic [7:0] a, input logic [31:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      tick();
      x = reg_rdata;
   endtask
   task automatic send(input logic [23:0] v);
      bus(0, 0, 0, 0);
      sample_valid <= 1;
      sample_data <= v;
      do begin
         @(posedge sys_clk);
         ok = sample_ready;
         #1;
      end while (!ok);
      sample_valid <= 0;
      sample_data <= ~v;
   endtask
   task automatic rst();
      bus(0, 0, 0, 0);
      rstn <= 0;
      repeat (2) tick();
      rstn <= 1;
      tick();
      display_sink_i.got.delete();
   endtask
   task automatic drain(input int n);
      for (int i = 0; i < 2000 && display_sink_i.got.size() < n; i++) tick();
      chk(display_sink_i.got.size(), n);
   endtask
   initial begin
      repeat (8) tick();
      chk({out_valid, filter_active_indicator, reg_rdata[29:0]}, 0);
      rstn <= 1;
      tick();
      foreach (rows[i]) begin
         rst();
         slow <= i[0];
         bus(1, 0, ADDR_MEAS, {rows[i].a, 2'b00, rows[i].m});
         bus(1, 0, ADDR_SETUP, {rows[i].c, 4'h0, rows[i].rk});
         bus(1, 0, ADDR_CONFIG, rows[i].en);
         bus(0, 1, ADDR_STATUS, 0);
         chk({x[6:4], x[0]}, {rows[i].a < 2 ? 3'h0 : rows[i].a - 3'h1, |rows[i].en});
         for (int k = 0; k < 8; k++) send(S[k]);
         drain(rows[i].n);
         for (int k = 0; k < rows[i].n; k++) begin
            chk(display_sink_i.got[k], rows[i].e[k]);
         end
      end
      rst();
      bus(0, 1, ADDR_STATUS, 0);
      chk(x, 32'h0000_0020);
      bus(0, 1, ADDR_SETUP, 0);
      chk(x, 32'h0000_0a00);
      bus(1, 0, ADDR_SETUP, 32'h0000_6502);
      bus(0, 1, ADDR_SETUP, 0);
      chk(x, 32'h0000_0a02);
      bus(1, 0, ADDR_SETUP, 32'h0000_0001);
      bus(0, 1, ADDR_SETUP, 0);
      chk(x, 32'h0000_0a01);
      bus(1, 0, ADDR_SETUP, 32'h0000_6403);
      bus(0, 1, ADDR_SETUP, 0);
      chk(x, 32'h0000_6403);
      bus(1, 0, ADDR_KEY, 2);
      bus(0, 1, ADDR_STATUS, 0);
      chk({x[2], x[0], filter_active_indicator}, 3'h7);
      bus(1, 0, ADDR_SETUP, 32'h0000_0a05);
      bus(0, 1, ADDR_STATUS, 0);
      chk({x[2], x[0]}, 2'h3);
      bus(1, 0, ADDR_KEY, 1);
      bus(0, 1, ADDR_STATUS, 0);
      chk({x[2:0], filter_active_indicator}, 0);
      bus(0, 1, ADDR_KEY, 0);
      chk(x, 0);
      bus(1, 0, 8'h40, 32'hffff_ffff);
      bus(0, 1, 8'h40, 0);
      chk(x, 0);
      // fifo fill: the display side refuses until four words wait and the input stalls
      rst();
      hold <= 1;
      bus(1, 0, ADDR_MEAS, 0);
      for (int k = 0; k < 4; k++) send(S[k] + 24'h00_0010);
      repeat (4) tick();
      chk({sample_ready, out_valid}, 2'h1);
      bus(0, 1, ADDR_STATUS, 0);
      chk(x[10:8], 4);
      hold <= 0;
      bus(0, 0, 0, 0);
      drain(4);
      for (int k = 0; k < 4; k++) chk(display_sink_i.got[k], S[k] + 24'h00_0010);
      chk(out_valid, 0);
      test_done();
   end
endmodule
